// ### rtl/fpc_host.v
// Host-side controller driving a parallel flash through its control pins
// Flash rules this block works with, and what it does about them
// R1: Flash refuses program/erase under low program supply; host reports supply_low_flag.
// R2: Chip select low with reset high means active; host accesses only then.
// R3: After a read with stable address the flash idles holding data.
// R4: Host raises chip select when idle, putting the flash in standby.
// R5: In standby the flash floats data regardless of output drive.
// R6: Chip select high mid-operation lets the flash finish it.
// R7: Reset/power-down low deselects, floats outputs, enters deep power-down.
// R8: After releasing reset/power-down, host waits recovery time before reading.
// R9: Reset/power-down low during program/erase aborts it; data becomes invalid.
// R10: Deep power-down clears the status register.
// R11: Writes only with write strobe and chip select both low.
// R12: Memory changes only after a full two-cycle command sequence.
// R13: While reset/power-down is low all control inputs are ignored.
// R14: Latched command survives chip-select and supply transitions.
// R15: Command interface defaults to read-array after reset.
// R16: After program/erase host issues read-array before reading array data.
// R17: Reset/power-down follows the system reset.
// R18: Recovery time is a parameter; reads wait until it elapses.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.vh"
module fpc_host #(
	parameter AW = 22,
	parameter DW = 16,
	parameter RECOVERY_CYC = `FPC_RECOVERY_CYC,
	parameter RESET_LOW_CYC = `FPC_RESET_LOW_CYC
) (
	input wire clk_in,
	input wire arst_n_in,
	input wire req_in,
	input wire [1:0] op_in,
	input wire [AW-1:0] addr_in,
	input wire [DW-1:0] wdata_in,
	input wire powerdown_in,
	input wire [DW-1:0] dq_in,
	output reg [DW-1:0] dq_out,
	output reg dq_oe_n_out,
	output reg [AW-1:0] addr_out,
	output reg chip_select_n_out,
	output reg write_strobe_n_out,
	output reg output_drive_n_out,
	output reg reset_powerdown_n_out,
	output reg busy_out,
	output reg done_out,
	output reg [DW-1:0] rdata_out,
	output reg supply_low_flag_out,
	output reg op_error_out,
	output reg ready_out
);
	localparam S_PD = 4'h0;
	localparam S_RECOVER = 4'h1;
	localparam S_IDLE = 4'h2;
	localparam S_W1_SETUP = 4'h3;
	localparam S_W1_STROBE = 4'h4;
	localparam S_W1_HOLD = 4'h5;
	localparam S_RD_SETUP = 4'h6;
	localparam S_RD_SAMPLE = 4'h7;
	localparam S_POLL = 4'h8;
	localparam S_DONE = 4'h9;
	localparam [1:0] PH_CMD = 2'h0;
	localparam [1:0] PH_DATA = 2'h1;
	localparam [1:0] PH_RESTORE = 2'h2;
	localparam [`FPC_CNT_W-1:0] REC_CYC = RECOVERY_CYC[`FPC_CNT_W-1:0];
	localparam [`FPC_CNT_W-1:0] RLOW_CYC = RESET_LOW_CYC[`FPC_CNT_W-1:0];

	reg [3:0] st_r;
	reg [1:0] ph_r;
	reg [1:0] op_r;
	reg [`FPC_CNT_W-1:0] cnt_r;
	reg [DW-1:0] wd_r;
	reg [2:0] pd_sync_r;
	reg [DW-1:0] dq_s1_r;
	reg [DW-1:0] dq_s2_r;
	reg pd_lvl_r;
	// First-cycle command byte for each operation
	function [7:0] first_cmd;
		input [1:0] op;
		begin
			case (op)
			`FPC_OP_PROGRAM: first_cmd = `FPC_CMD_PROGRAM;
			`FPC_OP_ERASE: first_cmd = `FPC_CMD_ERASE;
			`FPC_OP_STATUS: first_cmd = `FPC_CMD_READ_STATUS;
			default: first_cmd = `FPC_CMD_READ_ARRAY;
			endcase
		end
	endfunction
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pd_sync_r <= 3'h0;
			pd_lvl_r <= 1'b0;
			dq_s1_r <= {DW{1'b0}};
			dq_s2_r <= {DW{1'b0}};
		end else begin
			pd_sync_r <= {pd_sync_r[1:0], powerdown_in};
			pd_lvl_r <= (pd_sync_r[1] == pd_sync_r[2]) ? pd_sync_r[2] : pd_lvl_r;
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	wire pd_req = pd_lvl_r;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			// R17: system reset
			st_r <= S_PD;
			ph_r <= PH_CMD;
			op_r <= `FPC_OP_READ;
			cnt_r <= {`FPC_CNT_W{1'b0}};
			wd_r <= {DW{1'b0}};
			dq_out <= {DW{1'b0}};
			dq_oe_n_out <= 1'b1;
			addr_out <= {AW{1'b0}};
			chip_select_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			output_drive_n_out <= 1'b1;
			reset_powerdown_n_out <= 1'b0;
			busy_out <= 1'b1;
			done_out <= 1'b0;
			rdata_out <= {DW{1'b0}};
			supply_low_flag_out <= 1'b0;
			op_error_out <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (pd_req && st_r != S_PD) begin
				// R7: deep power-down, all strobes released
				// R9: aborts a running program or erase
				st_r <= S_PD;
				cnt_r <= {`FPC_CNT_W{1'b0}};
				reset_powerdown_n_out <= 1'b0;
				chip_select_n_out <= 1'b1;
				write_strobe_n_out <= 1'b1;
				output_drive_n_out <= 1'b1;
				dq_oe_n_out <= 1'b1;
				busy_out <= 1'b1;
				ready_out <= 1'b0;
				// R10: status cleared by power-down
				supply_low_flag_out <= 1'b0;
				op_error_out <= 1'b0;
			end else begin
				case (st_r)
				S_PD: begin
					// R13: hold low a minimum time, nothing else driven
					if (cnt_r < RLOW_CYC) begin
						cnt_r <= cnt_r + 1'b1;
					end else if (!pd_req) begin
						reset_powerdown_n_out <= 1'b1;
						cnt_r <= {`FPC_CNT_W{1'b0}};
						st_r <= S_RECOVER;
					end
				end
				S_RECOVER: begin
					// R8: recovery time before any read
					// R18: count is a parameter
					if (cnt_r + 1'b1 >= REC_CYC) begin
						st_r <= S_IDLE;
						busy_out <= 1'b0;
						ready_out <= 1'b1;
						// R15: flash starts in read-array mode
						ph_r <= PH_DATA;
						op_r <= `FPC_OP_READ;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				S_IDLE: begin
					// R4: chip select high while idle gives standby
					chip_select_n_out <= 1'b1;
					if (req_in) begin
						op_r <= op_in;
						addr_out <= addr_in;
						wd_r <= wdata_in;
						busy_out <= 1'b1;
						ready_out <= 1'b0;
						done_out <= 1'b0;
						// R14: flash keeps read mode, so plain reads skip the command
						if (op_in == `FPC_OP_READ && op_r == `FPC_OP_READ) begin
							st_r <= S_RD_SETUP;
						end else begin
							ph_r <= PH_CMD;
							dq_out <= {{(DW-8){1'b0}}, first_cmd(op_in)};
							st_r <= S_W1_SETUP;
						end
					end
				end
				S_W1_SETUP: begin
					// R2: active mode for the access
					chip_select_n_out <= 1'b0;
					output_drive_n_out <= 1'b1;
					dq_oe_n_out <= 1'b0;
					st_r <= S_W1_STROBE;
				end
				S_W1_STROBE: begin
					// R11: write only with both strobes low
					write_strobe_n_out <= 1'b0;
					st_r <= S_W1_HOLD;
				end
				S_W1_HOLD: begin
					write_strobe_n_out <= 1'b1;
					chip_select_n_out <= 1'b1;
					st_r <= S_W1_SETUP;
					// R12: program and erase take a second cycle
					if (ph_r == PH_CMD && (op_r == `FPC_OP_PROGRAM || op_r == `FPC_OP_ERASE)) begin
						ph_r <= PH_DATA;
						dq_out <= (op_r == `FPC_OP_ERASE) ?
							{{(DW-8){1'b0}}, `FPC_CMD_ERASE_CONFIRM} : wd_r;
					end else if (ph_r == PH_DATA && op_r != `FPC_OP_READ) begin
						// R6: chip select may rise while the flash works
						dq_oe_n_out <= 1'b1;
						st_r <= S_POLL;
						cnt_r <= {`FPC_CNT_W{1'b0}};
					end else if (ph_r == PH_RESTORE) begin
						dq_oe_n_out <= 1'b1;
						op_r <= `FPC_OP_READ;
						ph_r <= PH_DATA;
						st_r <= S_DONE;
					end else begin
						dq_oe_n_out <= 1'b1;
						ph_r <= PH_DATA;
						st_r <= S_RD_SETUP;
					end
				end
				S_RD_SETUP: begin
					chip_select_n_out <= 1'b0;
					output_drive_n_out <= 1'b0;
					cnt_r <= {`FPC_CNT_W{1'b0}};
					st_r <= S_RD_SAMPLE;
				end
				S_RD_SAMPLE: begin
					// Two-stage data path plus access time before capture
					if (cnt_r == 8'h03) begin
						rdata_out <= dq_s2_r;
						// R3: address stays put after the read
						output_drive_n_out <= 1'b1;
						chip_select_n_out <= 1'b1;
						busy_out <= 1'b0;
						ready_out <= 1'b1;
						done_out <= 1'b1;
						st_r <= S_IDLE;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				S_POLL: begin
					chip_select_n_out <= 1'b0;
					output_drive_n_out <= 1'b0;
					if (cnt_r == 8'h03) begin
						cnt_r <= {`FPC_CNT_W{1'b0}};
						output_drive_n_out <= 1'b1;
						chip_select_n_out <= 1'b1;
						if (dq_s2_r[`FPC_SR_READY_BIT]) begin
							// R1: supply-low abort reported
							supply_low_flag_out <= dq_s2_r[`FPC_SR_SUPPLY_LOW_BIT];
							op_error_out <= |dq_s2_r[5:1];
							// R16: back to read-array before array reads
							ph_r <= PH_RESTORE;
							dq_out <= {{(DW-8){1'b0}}, `FPC_CMD_READ_ARRAY};
							st_r <= S_W1_SETUP;
						end
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				S_DONE: begin
					busy_out <= 1'b0;
					ready_out <= 1'b1;
					done_out <= 1'b1;
					st_r <= S_IDLE;
				end
				default: st_r <= S_PD;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/fpc_defines.vh
// Constants for the flash power-mode and reset host controller
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
`define FPC_CLK_PERIOD_NS 50
`define FPC_RECOVERY_NS 150
`define FPC_RECOVERY_CYC ((`FPC_RECOVERY_NS + `FPC_CLK_PERIOD_NS - 1) / `FPC_CLK_PERIOD_NS)
`define FPC_RESET_LOW_NS 100
`define FPC_RESET_LOW_CYC ((`FPC_RESET_LOW_NS + `FPC_CLK_PERIOD_NS - 1) / `FPC_CLK_PERIOD_NS)
`define FPC_CNT_W 8
`define FPC_CMD_READ_ARRAY 8'hFF
`define FPC_CMD_READ_STATUS 8'h70
`define FPC_CMD_CLEAR_STATUS 8'h50
`define FPC_CMD_PROGRAM 8'h40
`define FPC_CMD_ERASE 8'h20
`define FPC_CMD_ERASE_CONFIRM 8'hD0
`define FPC_SR_READY_BIT 7
`define FPC_SR_SUPPLY_LOW_BIT 3
`define FPC_OP_PROGRAM 2'h0
`define FPC_OP_ERASE 2'h1
`define FPC_OP_READ 2'h2
`define FPC_OP_STATUS 2'h3
`endif

// ### verif/fpc_host_assertions.sv
// Pin checker for the flash host
`timescale 1ns/1ps
`default_nettype none
module fpc_chk #(parameter DW = 16) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [DW-1:0] dq_out,
	input wire logic chip_select_n_out,
	input wire logic write_strobe_n_out,
	input wire logic output_drive_n_out,
	input wire logic reset_powerdown_n_out,
	input wire logic done_out
);
	// Power-down returns the flash to read-array mode, so forget the command
	logic [7:0] cmd_r;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cmd_r <= 8'hFF;
		end else if (!reset_powerdown_n_out || !write_strobe_n_out) begin
			cmd_r <= reset_powerdown_n_out ? dq_out[7:0] : 8'hFF;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	reset_hold_a: assert property ($rose(arst_n_in) |-> !reset_powerdown_n_out [*2])
		else $error("flash reset released too early");
	recovery_wait_a: assert property ($rose(reset_powerdown_n_out) |-> output_drive_n_out [*3])
		else $error("read inside recovery time");
	write_gate_a: assert property (!write_strobe_n_out |-> !chip_select_n_out
		&& reset_powerdown_n_out && output_drive_n_out) else $error("write strobe not gated");
	read_mode_a: assert property ($rose(done_out) |-> cmd_r == 8'hFF || cmd_r == 8'h70)
		else $error("done without read-array command");
endmodule
`default_nettype wire

// ### verif/fpc_flash.sv
// Behavioural flash device
`timescale 1ns/1ps
`default_nettype none
module fpc_flash #(parameter REC_NS = 150, parameter BUSY_NS = 2000) (
	input wire logic pd_n_in,
	input wire logic cs_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic low_in,
	input wire logic [3:0] a_in,
	input wire logic [15:0] d_in,
	output logic [15:0] q_out
);
	logic [15:0] mem [0:15];
	logic [15:0] tv;
	logic [7:0] sr = 8'h80;
	logic [3:0] ta;
	logic [1:0] pend = 0;
	logic st = 0, rec = 1, busy = 0;
	integer i;
	initial for (i = 0; i < 16; i++) mem[i] = 16'h1234;
	always @(negedge pd_n_in) begin
		if (busy) mem[ta] = ~tv;
		{busy, st, pend, rec, sr} = 0;
	end
	always @(posedge pd_n_in) begin
		sr = 8'h80;
		#REC_NS rec = 1;
	end
	always @(negedge we_n_in) if (!cs_n_in && pd_n_in && !busy) begin
		if (pend) begin
			st = 1;
			if (low_in) sr[3] = 1;
			else if (pend == 1 || d_in[7:0] == 8'hD0) begin
				ta = a_in;
				tv = (pend == 1) ? d_in : 16'hFFFF;
				{busy, sr[7]} = 2'b10;
			end
			pend = 0;
		end else begin
			pend = d_in[7:0] == 8'h40 ? 1 : d_in[7:0] == 8'h20 ? 2 : 0;
			st = d_in[7:0] != 8'hFF;
		end
	end
	always @(posedge busy) begin
		#BUSY_NS;
		if (busy) begin
			for (i = 0; i < 16; i++) if (tv == 16'hFFFF || i == ta) mem[i] = tv;
			{busy, sr[7]} = 2'b01;
		end
	end
	wire [15:0] v = st ? {8'h00, sr} : mem[a_in];
	assign q_out = (!cs_n_in && !oe_n_in && pd_n_in && rec) ? v : ~v;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Bench for the flash host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_in = 0, arst_n_in = 0, req_in = 0, powerdown_in = 0, low = 0;
	logic [1:0] op_in = 0;
	logic [3:0] addr_in = 0;
	logic [15:0] wdata_in = 0;
	wire [15:0] dq_in, dq_out, q, rd;
	wire [3:0] ad;
	wire oe_n, cs_n, we_n, rd_n, pd_n, done, slf, ready, busy, oerr;
	integer fails = 0, n_checks = 0, i;
	always #25 clk_in = ~clk_in;
	assign dq_in = oe_n ? q : dq_out;
	fpc_host #(.AW(4), .DW(16)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req_in),
		.op_in(op_in), .addr_in(addr_in), .wdata_in(wdata_in), .powerdown_in(powerdown_in),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_n_out(oe_n), .addr_out(ad),
		.chip_select_n_out(cs_n), .write_strobe_n_out(we_n), .output_drive_n_out(rd_n),
		.reset_powerdown_n_out(pd_n), .busy_out(busy), .done_out(done), .rdata_out(rd),
		.supply_low_flag_out(slf), .op_error_out(oerr), .ready_out(ready));
	fpc_flash flash (.pd_n_in(pd_n), .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(rd_n),
		.low_in(low), .a_in(ad), .d_in(dq_in), .q_out(q));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task wait_for(input logic sel);
		for (i = 0; i < 300; i++) begin
			@(negedge clk_in);
			if ((sel ? done : ready) === 1'b1) return;
		end
		chk(0, 1);
		end_of_test;
	endtask
	task start(input logic [1:0] o, input logic [3:0] a, input logic [15:0] d);
		wait_for(0);
		@(posedge clk_in);
		{op_in, addr_in, wdata_in, req_in} <= {o, a, d, 1'b1};
		@(posedge clk_in);
		req_in <= 0;
	endtask
	task run(input logic [1:0] o, input logic [3:0] a, input logic [15:0] d);
		start(o, a, d);
		wait_for(1);
	endtask
	task t_prog_erase;
		run(2, 4'h5, 0);
		chk(rd, 16'h1234);
		chk(busy, 0);
		run(0, 4'h3, 16'hBEEF);
		chk(slf, 0);
		chk(oerr, 0);
		run(2, 4'h3, 0);
		chk(rd, 16'hBEEF);
		run(1, 4'h3, 0);
		run(2, 4'h9, 0);
		chk(rd, 16'hFFFF);
		$display("program erase end");
	endtask
	task t_lockout;
		low <= 1;
		run(0, 4'h6, 16'h0F0F);
		chk(slf, 1);
		chk(oerr, 1);
		low <= 0;
		run(2, 4'h6, 0);
		chk(rd, 16'hFFFF);
		$display("lockout end");
	endtask
	task t_abort;
		start(1, 4'h3, 0);
		repeat (12) @(posedge clk_in);
		chk(busy, 1);
		powerdown_in <= 1;
		repeat (10) @(posedge clk_in);
		powerdown_in <= 0;
		run(3, 0, 0);
		chk(slf, 0);
		chk(oerr, 0);
		chk(rd, 16'h0080);
		run(2, 4'h3, 0);
		chk(rd, 16'h0000);
		$display("abort end");
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		arst_n_in <= 1;
		t_prog_erase;
		t_lockout;
		t_abort;
		end_of_test;
	end
endmodule
bind fpc_host fpc_chk #(.DW(DW)) chk_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
	.dq_out(dq_out), .chip_select_n_out(chip_select_n_out),
	.write_strobe_n_out(write_strobe_n_out), .output_drive_n_out(output_drive_n_out),
	.reset_powerdown_n_out(reset_powerdown_n_out), .done_out(done_out));
`default_nettype wire
